//--- pkg/timer16_pkg.sv
package timer16_pkg;

   // bus and datapath widths
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 8;
   localparam int CNT_W     = 16;
   localparam int IRQ_W     = 3;
   localparam int PRESCALE_W = 10;

   // register byte addresses
   localparam logic [7:0] OFS_CTRL_A   = 8'h2f;
   localparam logic [7:0] OFS_CTRL_B   = 8'h2e;
   localparam logic [7:0] OFS_CNT_L    = 8'h2c;
   localparam logic [7:0] OFS_CNT_H    = 8'h2d;
   localparam logic [7:0] OFS_CMPA_L   = 8'h2a;
   localparam logic [7:0] OFS_CMPA_H   = 8'h2b;
   localparam logic [7:0] OFS_CMPB_L   = 8'h28;
   localparam logic [7:0] OFS_CMPB_H   = 8'h29;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0b;

   // reset values and writable bits
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [7:0] CTRL_A_WMASK   = 8'hf3;
   localparam logic [7:0] CTRL_B_WMASK   = 8'hdf;
   localparam logic [7:0] BYTE_ZERO      = 8'h00;
   localparam logic [2:0] IRQ_ZERO       = 3'h0;

   // control field positions
   localparam int COM_A_MSB = 7;
   localparam int COM_A_LSB = 6;
   localparam int COM_B_MSB = 5;
   localparam int COM_B_LSB = 4;
   localparam int WGM_LO_MSB = 1;
   localparam int WGM_LO_LSB = 0;
   localparam int WGM_HI_MSB = 4;
   localparam int WGM_HI_LSB = 3;
   localparam int CS_MSB    = 2;
   localparam int CS_LSB    = 0;

   // interrupt status and mask bits
   localparam int IRQ_OVF  = 0;
   localparam int IRQ_CMPA = 1;
   localparam int IRQ_CMPB = 2;

   // count limits
   localparam logic [15:0] TOP_MAX = 16'hffff;
   localparam logic [15:0] TOP_8   = 16'h00ff;
   localparam logic [15:0] TOP_9   = 16'h01ff;
   localparam logic [15:0] TOP_10  = 16'h03ff;
   localparam logic [15:0] BOTTOM  = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;

   // prescaler taps
   localparam logic [9:0] DIV8_MASK    = 10'h007;
   localparam logic [9:0] DIV64_MASK   = 10'h03f;
   localparam logic [9:0] DIV256_MASK  = 10'h0ff;
   localparam logic [9:0] DIV1024_MASK = 10'h3ff;
   localparam logic [9:0] DIV_ONE      = 10'h001;

   typedef enum logic [3:0] {
      MODE_NORMAL   = 4'b0000,
      MODE_PC8      = 4'b0001,
      MODE_PC9      = 4'b0010,
      MODE_PC10     = 4'b0011,
      MODE_CTC_CMP  = 4'b0100,
      MODE_FAST8    = 4'b0101,
      MODE_FAST9    = 4'b0110,
      MODE_FAST10   = 4'b0111,
      MODE_PFC_CAP  = 4'b1000,
      MODE_PFC_CMP  = 4'b1001,
      MODE_PC_CAP   = 4'b1010,
      MODE_PC_CMP   = 4'b1011,
      MODE_CTC_CAP  = 4'b1100,
      MODE_RESERVED = 4'b1101,
      MODE_FAST_CAP = 4'b1110,
      MODE_FAST_CMP = 4'b1111
   } wave_mode_t;

   typedef enum logic [2:0] {
      CS_STOP     = 3'b000,
      CS_DIV1     = 3'b001,
      CS_DIV8     = 3'b010,
      CS_DIV64    = 3'b011,
      CS_DIV256   = 3'b100,
      CS_DIV1024  = 3'b101,
      CS_EXT_FALL = 3'b110,
      CS_EXT_RISE = 3'b111
   } clock_sel_t;

   localparam logic [1:0] COM_OFF    = 2'b00;
   localparam logic [1:0] COM_TOGGLE = 2'b01;
   localparam logic [1:0] COM_CLEAR  = 2'b10;
   localparam logic [1:0] COM_SET    = 2'b11;

endpackage

//--- src/timer16_tick_prescaler.sv
`timescale 1ns/1ps
module timer16_tick_prescaler
   import timer16_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic [2:0] clock_select,
   input  wire logic       ext_clock_pin,
   output logic            timer_tick
);

   typedef struct packed {
      logic [PRESCALE_W-1:0] div;
      logic                  ext_prev;
      logic                  tick;
   } presc_state_t;

   presc_state_t st_reg;
   presc_state_t st_next;
   clock_sel_t   sel;

   // free running divider; taps give one-cycle enables, never a derived clock
   always_comb begin
      st_next          = st_reg;
      sel              = clock_sel_t'(clock_select);
      st_next.div      = st_reg.div + DIV_ONE;
      st_next.ext_prev = ext_clock_pin;
      case (sel)
         CS_STOP:     st_next.tick = 1'b0;
         CS_DIV1:     st_next.tick = 1'b1;
         CS_DIV8:     st_next.tick = (st_reg.div & DIV8_MASK) == DIV8_MASK;
         CS_DIV64:    st_next.tick = (st_reg.div & DIV64_MASK) == DIV64_MASK;
         CS_DIV256:   st_next.tick = (st_reg.div & DIV256_MASK) == DIV256_MASK;
         CS_DIV1024:  st_next.tick = st_reg.div == DIV1024_MASK;
         CS_EXT_FALL: st_next.tick = st_reg.ext_prev && !ext_clock_pin;
         CS_EXT_RISE: st_next.tick = !st_reg.ext_prev && ext_clock_pin;
         default:     st_next.tick = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign timer_tick = st_reg.tick;

   chk_stop_no_tick: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (clock_select == CS_STOP) |=> !timer_tick)
      else $error("tick seen with clock stopped");

   cover_ext_tick: cover property (
      @(posedge ref_clk) disable iff (!resetn)
      (clock_select == CS_EXT_RISE) ##1 timer_tick);

endmodule // timer16_tick_prescaler

//--- src/timer16_waveform_mode_control.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module timer16_waveform_mode_control
   import timer16_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic       [DATA_W-1:0] reg_rdata,
   input  wire logic              ext_clock_pin,
   input  wire logic [CNT_W-1:0]  capture_value,
   output logic                   compare_out_a,
   output logic                   compare_out_b,
   output logic                   pin_override_a,
   output logic                   pin_override_b,
   output logic                   irq
);

   typedef struct packed {
      logic [DATA_W-1:0] ctrl_a;
      logic [DATA_W-1:0] ctrl_b;
      logic [DATA_W-1:0] temp;
      logic [CNT_W-1:0]  cnt;
      logic [CNT_W-1:0]  cmp_a_buf;
      logic [CNT_W-1:0]  cmp_a;
      logic [CNT_W-1:0]  cmp_b_buf;
      logic [CNT_W-1:0]  cmp_b;
      logic              count_down;
      logic              block_match;
      logic [IRQ_W-1:0]  irq_stat;
      logic [IRQ_W-1:0]  irq_mask;
      logic              out_a;
      logic              out_b;
      logic              drive_a;
      logic              drive_b;
      logic              irq;
      logic [DATA_W-1:0] rdata;
   } wave_state_t;

   wave_state_t      st_reg;
   wave_state_t      st_next;
   wave_mode_t       mode;
   logic             timer_tick;
   logic [CNT_W-1:0] top_val;
   logic [CNT_W-1:0] top_mask;
   logic             is_fast;
   logic             is_dual;
   logic             is_pc;
   logic             immediate;
   logic             run;
   logic             at_top;
   logic             at_bottom;
   logic             match_a;
   logic             match_b;
   logic             ovf_evt;
   logic             update_evt;
   logic [IRQ_W-1:0] irq_evt;
   logic [CNT_W-1:0] wr_word;

   // tick source; stays a clock enable so no second domain exists
   timer16_tick_prescaler u_prescaler (
      .ref_clk       (ref_clk),
      .resetn        (resetn),
      .clock_select  (st_reg.ctrl_b[CS_MSB:CS_LSB]),
      .ext_clock_pin (ext_clock_pin),
      .timer_tick    (timer_tick)
   );

   // next pin level for one channel from its output-mode code
   function automatic logic next_out(
      input logic [1:0] com,
      input logic       fast,
      input logic       dual,
      input logic       match,
      input logic       ignore,
      input logic       bottom,
      input logic       up,
      input logic       toggle_ok,
      input logic       cur
   );
      logic o;
      o = cur;
      case (com)
         COM_TOGGLE: begin
            if (match && (!(fast || dual) || toggle_ok)) begin
               o = !cur;
            end
         end
         COM_CLEAR: begin
            if (fast) begin
               if (bottom) begin
                  o = 1'b1;
               end
               if (match && !ignore) begin
                  o = 1'b0;
               end
            end else if (dual) begin
               if (match) begin
                  o = !up;
               end
            end else if (match) begin
               o = 1'b0;
            end
         end
         COM_SET: begin
            if (fast) begin
               if (bottom) begin
                  o = 1'b0;
               end
               if (match && !ignore) begin
                  o = 1'b1;
               end
            end else if (dual) begin
               if (match) begin
                  o = up;
               end
            end else if (match) begin
               o = 1'b1;
            end
         end
         default: o = cur; // code 00 leaves the pin to the port
      endcase
      return o;
   endfunction

   // mode decode: count sequence, top source and update point
   always_comb begin
      mode = wave_mode_t'({st_reg.ctrl_b[WGM_HI_MSB:WGM_HI_LSB],
                           st_reg.ctrl_a[WGM_LO_MSB:WGM_LO_LSB]});
      top_val   = TOP_MAX;
      top_mask  = TOP_MAX;
      is_fast   = 1'b0;
      is_pc     = 1'b0;
      is_dual   = 1'b0;
      immediate = 1'b0;
      case (mode)
         MODE_NORMAL:   immediate = 1'b1;
         MODE_CTC_CMP:  begin
            immediate = 1'b1;
            top_val   = st_reg.cmp_a;
         end
         MODE_CTC_CAP:  begin
            immediate = 1'b1;
            top_val   = capture_value;
         end
         MODE_PC8:      begin
            is_pc    = 1'b1;
            top_val  = TOP_8;
            top_mask = TOP_8;
         end
         MODE_PC9:      begin
            is_pc    = 1'b1;
            top_val  = TOP_9;
            top_mask = TOP_9;
         end
         MODE_PC10:     begin
            is_pc    = 1'b1;
            top_val  = TOP_10;
            top_mask = TOP_10;
         end
         MODE_PC_CAP:   begin
            is_pc   = 1'b1;
            top_val = capture_value;
         end
         MODE_PC_CMP:   begin
            is_pc   = 1'b1;
            top_val = st_reg.cmp_a;
         end
         MODE_FAST8:    begin
            is_fast  = 1'b1;
            top_val  = TOP_8;
            top_mask = TOP_8;
         end
         MODE_FAST9:    begin
            is_fast  = 1'b1;
            top_val  = TOP_9;
            top_mask = TOP_9;
         end
         MODE_FAST10:   begin
            is_fast  = 1'b1;
            top_val  = TOP_10;
            top_mask = TOP_10;
         end
         MODE_FAST_CAP: begin
            is_fast = 1'b1;
            top_val = capture_value;
         end
         MODE_FAST_CMP: begin
            is_fast = 1'b1;
            top_val = st_reg.cmp_a;
         end
         MODE_PFC_CAP:  begin
            is_dual = 1'b1;
            top_val = capture_value;
         end
         MODE_PFC_CMP:  begin
            is_dual = 1'b1;
            top_val = st_reg.cmp_a;
         end
         default:       immediate = 1'b0; // reserved: held stopped
      endcase
      is_dual = is_dual || is_pc;
   end

   // counter, compare units, flags and the register port
   always_comb begin
      st_next    = st_reg;
      run        = timer_tick && (mode != MODE_RESERVED);
      at_top     = st_reg.cnt == top_val;
      at_bottom  = st_reg.cnt == BOTTOM;
      match_a    = run && !st_reg.block_match && (st_reg.cnt == st_reg.cmp_a);
      match_b    = run && !st_reg.block_match && (st_reg.cnt == st_reg.cmp_b);
      wr_word    = {st_reg.temp, reg_wdata};
      // overflow point per mode family
      if (is_fast) begin
         ovf_evt = run && at_top;
      end else if (is_dual) begin
         ovf_evt = run && at_bottom && st_reg.count_down;
      end else begin
         ovf_evt = run && (st_reg.cnt == TOP_MAX);
      end
      // double-buffer load point
      if (is_pc) begin
         update_evt = run && at_top && !st_reg.count_down;
      end else begin
         update_evt = run && at_bottom && (is_fast || is_dual);
      end
      // count sequence
      if (run) begin
         if (is_dual) begin
            if (!st_reg.count_down && at_top) begin
               st_next.count_down = 1'b1;
               st_next.cnt        = st_reg.cnt - CNT_ONE;
            end else if (st_reg.count_down && at_bottom) begin
               st_next.count_down = 1'b0;
               st_next.cnt        = st_reg.cnt + CNT_ONE;
            end else if (st_reg.count_down) begin
               st_next.cnt = st_reg.cnt - CNT_ONE;
            end else begin
               st_next.cnt = st_reg.cnt + CNT_ONE;
            end
         end else begin
            st_next.count_down = 1'b0;
            st_next.cnt        = at_top ? BOTTOM : st_reg.cnt + CNT_ONE;
         end
         st_next.block_match = 1'b0;
      end
      if (update_evt) begin
         st_next.cmp_a = st_reg.cmp_a_buf;
         st_next.cmp_b = st_reg.cmp_b_buf;
      end
      // output waveform per channel; B never toggles in PWM modes
      st_next.out_a = next_out(st_reg.ctrl_a[COM_A_MSB:COM_A_LSB], is_fast, is_dual, match_a,
                               is_fast && (st_reg.cmp_a == top_val), run && at_bottom,
                               !st_reg.count_down, mode[3], st_reg.out_a);
      st_next.out_b = next_out(st_reg.ctrl_a[COM_B_MSB:COM_B_LSB], is_fast, is_dual, match_b,
                               is_fast && (st_reg.cmp_b == top_val), run && at_bottom,
                               !st_reg.count_down, 1'b0, st_reg.out_b);
      irq_evt = '0;
      irq_evt[IRQ_OVF]  = ovf_evt;
      irq_evt[IRQ_CMPA] = match_a;
      irq_evt[IRQ_CMPB] = match_b;
      // register writes; a counter write suppresses the next tick's match
      if (reg_write) begin
         if (reg_addr == OFS_CTRL_A) begin
            st_next.ctrl_a = reg_wdata & CTRL_A_WMASK;
         end else if (reg_addr == OFS_CTRL_B) begin
            st_next.ctrl_b = reg_wdata & CTRL_B_WMASK;
         end else if (reg_addr == OFS_CNT_H || reg_addr == OFS_CMPA_H ||
                      reg_addr == OFS_CMPB_H) begin
            st_next.temp = reg_wdata;
         end else if (reg_addr == OFS_CNT_L) begin
            st_next.cnt         = wr_word;
            st_next.block_match = 1'b1;
         end else if (reg_addr == OFS_CMPA_L) begin
            st_next.cmp_a_buf = wr_word & top_mask;
            if (immediate) begin
               st_next.cmp_a = wr_word & top_mask;
            end
         end else if (reg_addr == OFS_CMPB_L) begin
            st_next.cmp_b_buf = wr_word & top_mask;
            if (immediate) begin
               st_next.cmp_b = wr_word & top_mask;
            end
         end else if (reg_addr == OFS_IRQ_MASK) begin
            st_next.irq_mask = reg_wdata[IRQ_W-1:0];
         end
      end
      // reads: data in the following cycle only, zero elsewhere
      st_next.rdata = BYTE_ZERO;
      st_next.irq_stat = st_reg.irq_stat | irq_evt;
      if (reg_read) begin
         if (reg_addr == OFS_CTRL_A) begin
            st_next.rdata = st_reg.ctrl_a;
         end else if (reg_addr == OFS_CTRL_B) begin
            st_next.rdata = st_reg.ctrl_b;
         end else if (reg_addr == OFS_CNT_L) begin
            st_next.rdata = st_reg.cnt[7:0];
            st_next.temp  = st_reg.cnt[15:8]; // high byte frozen with the low
         end else if (reg_addr == OFS_CNT_H) begin
            st_next.rdata = st_reg.temp;
         end else if (reg_addr == OFS_CMPA_L) begin
            st_next.rdata = st_reg.cmp_a_buf[7:0];
         end else if (reg_addr == OFS_CMPA_H) begin
            st_next.rdata = st_reg.cmp_a_buf[15:8];
         end else if (reg_addr == OFS_CMPB_L) begin
            st_next.rdata = st_reg.cmp_b_buf[7:0];
         end else if (reg_addr == OFS_CMPB_H) begin
            st_next.rdata = st_reg.cmp_b_buf[15:8];
         end else if (reg_addr == OFS_IRQ_MASK) begin
            st_next.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_reg.irq_mask};
         end else if (reg_addr == OFS_IRQ_STAT) begin
            st_next.rdata    = {{(DATA_W-IRQ_W){1'b0}}, st_reg.irq_stat};
            st_next.irq_stat = irq_evt; // read clears, a new event still wins
         end
      end
      st_next.drive_a = |st_next.ctrl_a[COM_A_MSB:COM_A_LSB];
      st_next.drive_b = |st_next.ctrl_a[COM_B_MSB:COM_B_LSB];
      st_next.irq     = |(st_next.irq_stat & st_next.irq_mask);
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg        <= '0;
         st_reg.ctrl_a <= CTRL_RESET;
         st_reg.ctrl_b <= CTRL_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata      = st_reg.rdata;
   assign compare_out_a  = st_reg.out_a;
   assign compare_out_b  = st_reg.out_b;
   assign pin_override_a = st_reg.drive_a;
   assign pin_override_b = st_reg.drive_b;
   assign irq            = st_reg.irq;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   chk_count_needs_tick: assert property (
      ($changed(st_reg.cnt) && !$past(reg_write && reg_addr == OFS_CNT_L)) |-> $past(timer_tick))
      else $error("counter moved without a tick");
   chk_buffered_hold: assert property (
      (!immediate && $stable(mode) && $changed(st_reg.cmp_a) &&
       !$past(reg_write && reg_addr == OFS_CMPA_L)) |-> $past(update_evt))
      else $error("buffered compare changed off its update point");
   chk_override_cause: assert property (
      $rose(pin_override_a) |-> $past(reg_write && reg_addr == OFS_CTRL_A))
      else $error("pin override rose without a control write");
   chk_nonpwm_toggle: assert property (
      (!is_fast && !is_dual && match_a &&
       st_reg.ctrl_a[COM_A_MSB:COM_A_LSB] == COM_TOGGLE) |=> (compare_out_a != $past(compare_out_a)))
      else $error("toggle on match missing");
   chk_pwm_b_reserved: assert property (
      ((is_fast || is_dual) && st_reg.ctrl_a[COM_B_MSB:COM_B_LSB] == COM_TOGGLE) |=> $stable(compare_out_b))
      else $error("channel b moved under code 01 in pwm");
   chk_fast_bottom_set: assert property (
      (is_fast && run && at_bottom && !match_a &&
       st_reg.ctrl_a[COM_A_MSB:COM_A_LSB] == COM_CLEAR) |=> compare_out_a)
      else $error("fast pwm output not set at bottom");
   chk_fast_top_ignore: assert property (
      (is_fast && match_a && !at_bottom && st_reg.cmp_a == top_val &&
       st_reg.ctrl_a[COM_A_MSB]) |=> $stable(compare_out_a))
      else $error("match at top not ignored");
   chk_dual_up_clear: assert property (
      (is_dual && match_a && !st_reg.count_down &&
       st_reg.ctrl_a[COM_A_MSB:COM_A_LSB] == COM_CLEAR) |=> !compare_out_a)
      else $error("up-count match did not clear");
   // a counter write in the same cycle legally overrides the wrap
   chk_normal_ovf: assert property (
      (mode == MODE_NORMAL && run && st_reg.cnt == TOP_MAX &&
       !(reg_write && reg_addr == OFS_CNT_L)) |=>
      (st_reg.irq_stat[IRQ_OVF] && st_reg.cnt == BOTTOM))
      else $error("normal mode wrap or overflow wrong");
   chk_pc8_turn: assert property (
      (mode == MODE_PC8 && run && !st_reg.count_down && st_reg.cnt == TOP_8 &&
       !(reg_write && reg_addr == OFS_CNT_L)) |=> st_reg.count_down)
      else $error("phase correct did not turn at top");
   chk_ctrl_a_rsvd: assert property (
      (reg_read && reg_addr == OFS_CTRL_A) |=> (reg_rdata & ~CTRL_A_WMASK) == BYTE_ZERO)
      else $error("reserved control bits read nonzero");

   cover_fast_cycle: cover property (is_fast && run && at_top ##[1:20] run && at_bottom);
   cover_dual_turn: cover property (is_dual && $rose(st_reg.count_down));
   cover_irq_rise: cover property ($rose(irq));

endmodule // timer16_waveform_mode_control

//--- dv/timer16_waveform_mode_control_bench.sv
`timescale 1ns/1ps
module timer16_waveform_mode_control_bench
   import timer16_pkg::*;
   ;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] ov;} row_t;
   typedef struct {logic [15:0] c; logic [15:0] cb; logic [7:0] ctl; int hi; int hb;} pwm_t;
   logic              ref_clk = 1'b0;
   logic              resetn = 1'b0;
   logic [7:0]        reg_addr = 8'h00;
   logic [7:0]        reg_wdata = 8'h00;
   logic              reg_write = 1'b0;
   logic              reg_read = 1'b0;
   logic [7:0]        reg_rdata;
   logic              compare_out_a;
   logic              compare_out_b;
   logic              pin_override_a;
   logic              pin_override_b;
   logic              irq;
   logic [7:0]        d;
   logic              prev;
   int                n;
   int                nb;
   int                error_cnt = 0;
   int                tests_run = 0;
   // writes then read-back; ctrl b rows leave the clock stopped
   row_t rows[8] = '{'{8'h2f, 8'hff, 8'hf3, 2'b11}, '{8'h2f, 8'h40, 8'h40, 2'b10},
      '{8'h2f, 8'h10, 8'h10, 2'b01}, '{8'h2f, 8'h00, 8'h00, 2'b00},
      '{8'h2e, 8'h18, 8'h18, 2'b00}, '{8'h2e, 8'h20, 8'h00, 2'b00},
      '{8'h0c, 8'h07, 8'h07, 2'b00}, '{8'h10, 8'h5a, 8'h00, 2'b00}};
   // fast pwm 8-bit: high cycles of a and b per 256-cycle period
   pwm_t pwm[3] = '{'{16'h0040, 16'h0020, 8'ha1, 64, 32},
      '{16'h0040, 16'h0020, 8'hf1, 192, 224}, '{16'h00ff, 16'h00ff, 8'ha1, 256, 256}};
   always #4 ref_clk = ~ref_clk;
   // external pin and capture unused by these scenarios
   timer16_waveform_mode_control timer16_waveform_mode_control_inst (
      .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .ext_clock_pin(1'b0), .capture_value(16'h0000), .compare_out_a(compare_out_a),
      .compare_out_b(compare_out_b), .pin_override_a(pin_override_a),
      .pin_override_b(pin_override_b), .irq(irq));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // entered just after a rising edge; strobe lasts one cycle
   // one idle edge after, so back-to-back writes never reassign the strobe in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   // data stand only in the cycle after the strobe, so sample mid-cycle
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
      @(posedge ref_clk);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // watchdog far beyond the few thousand cycles needed
   initial begin
      #100000;
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      rd(OFS_CTRL_A);
      chk("ctrl_a", d, 8'h00);
      rd(OFS_CTRL_B);
      chk("ctrl_b", d, 8'h00);
      chk("pin_override", {pin_override_a, pin_override_b}, 2'b00);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         chk("reg_rdata", d, rows[i].e);
         chk("pin_override", {pin_override_a, pin_override_b}, rows[i].ov);
      end
      $display("test registers done");
      // ctc on compare a = 3: period of four ticks, toggle each match
      wr(OFS_IRQ_MASK, 8'h00);
      wr(OFS_CMPA_H, 8'h00);
      wr(OFS_CMPA_L, 8'h03);
      wr(OFS_CTRL_A, 8'h40);
      wr(OFS_CTRL_B, 8'h09);
      repeat (4) @(posedge ref_clk);
      n = 0;
      prev = compare_out_a;
      repeat (16) begin
         @(negedge ref_clk);
         if (compare_out_a !== prev) n++;
         prev = compare_out_a;
      end
      chk("toggles", n, 4);
      chk("irq", irq, 1'b0);
      @(posedge ref_clk);
      wr(OFS_IRQ_MASK, 8'h02);
      repeat (2) @(posedge ref_clk);
      chk("irq", irq, 1'b1);
      wr(OFS_CTRL_A, 8'hc0);
      repeat (8) @(posedge ref_clk);
      chk("out_set", compare_out_a, 1'b1);
      wr(OFS_CTRL_A, 8'h80);
      repeat (8) @(posedge ref_clk);
      chk("out_clear", compare_out_a, 1'b0);
      wr(OFS_CTRL_B, 8'h00);
      repeat (2) @(posedge ref_clk);
      rd(OFS_IRQ_STAT);
      chk("status", d, 8'h06);
      repeat (2) @(posedge ref_clk);
      chk("irq", irq, 1'b0);
      $display("test ctc done");
      foreach (pwm[i]) begin
         wr(OFS_CMPA_H, pwm[i].c[15:8]);
         wr(OFS_CMPA_L, pwm[i].c[7:0]);
         wr(OFS_CMPB_H, pwm[i].cb[15:8]);
         wr(OFS_CMPB_L, pwm[i].cb[7:0]);
         wr(OFS_CTRL_A, pwm[i].ctl);
         wr(OFS_CTRL_B, 8'h09);
         repeat (520) @(posedge ref_clk);
         n = 0;
         nb = 0;
         repeat (256) begin
            @(negedge ref_clk);
            if (compare_out_a === 1'b1) n++;
            if (compare_out_b === 1'b1) nb++;
         end
         @(posedge ref_clk);
         chk("pwm_high", n, pwm[i].hi);
         chk("pwm_b_high", nb, pwm[i].hb);
      end
      $display("test fast pwm done");
      // phase correct 8-bit: period 510, high for twice the compare value;
      // b on code 01 with mode bit 3 low must keep its last level
      wr(OFS_CMPA_H, 8'h00);
      wr(OFS_CMPA_L, 8'h40);
      wr(OFS_CTRL_A, 8'h91);
      wr(OFS_CTRL_B, 8'h01);
      repeat (520) @(posedge ref_clk);
      n = 0;
      repeat (510) begin
         @(negedge ref_clk);
         if (compare_out_a === 1'b1) n++;
      end
      @(posedge ref_clk);
      chk("pc_high", n, 128);
      chk("b_reserved", {pin_override_b, compare_out_b}, 2'b11);
      $display("test phase correct done");
      stop_test();
   end
endmodule // timer16_waveform_mode_control_bench
